// File: shared/counter_cmd_pkg.sv
// Constants for the counter command port: register map, command codes,
// reset values and execution timing.
// Assumes a 32-bit APB slave on a 25 MHz pclk.
package counter_cmd_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] OFF_COUNTER_COMMAND   = 12'h000;
  localparam logic [11:0] OFF_COUNTER_DATA_HIGH = 12'h004;
  localparam logic [11:0] OFF_COUNTER_DATA_MID  = 12'h008;
  localparam logic [11:0] OFF_COUNTER_DATA_LOW  = 12'h00C;
  localparam logic [11:0] OFF_STATUS            = 12'h010;
  localparam logic [11:0] OFF_PULSE_COUNT       = 12'h014;
  localparam logic [11:0] OFF_DEVIATION_COUNT   = 12'h018;
  localparam logic [11:0] OFF_PULSE_CMP_BASE    = 12'h020;
  localparam logic [11:0] OFF_DEV_CMP1          = 12'h034;
  localparam logic [11:0] OFF_DEV_CMP2          = 12'h038;
  localparam logic [11:0] OFF_LAST_COMMAND      = 12'h03C;

  // Command codes held in the low nibble of the command byte.
  localparam logic [3:0] CMD_PULSE_PRESET = 4'h0;
  localparam logic [3:0] CMD_PULSE_CMP1   = 4'h1;
  localparam logic [3:0] CMD_PULSE_CMP5   = 4'h5;
  localparam logic [3:0] CMD_DEV_PRESET   = 4'h6;
  localparam logic [3:0] CMD_DEV_CMP1     = 4'h7;
  localparam logic [3:0] CMD_DEV_CMP2     = 4'h8;

  // Reset values.
  localparam logic [23:0] RST_COUNT     = 24'h000000;
  localparam logic [23:0] RST_PULSE_CMP = 24'h800000;
  localparam logic [23:0] RST_DEV_CMP   = 24'h000000;
  localparam logic [7:0]  RST_DATA_BYTE = 8'h00;

  // Execution time limit and clock rate.
  localparam int CLK_PERIOD_NS = 40;
  localparam int CMD_MAX_NS    = 200;
  localparam int CMD_MAX_CYC   = CMD_MAX_NS / CLK_PERIOD_NS;
  // Cycles the command stays busy after the write (well within the limit).
  localparam logic [2:0] CMD_BUSY_CYC = 3'h1;

endpackage : counter_cmd_pkg

// File: logic/counter_cmd_exec.sv
// Command executor: decodes a latched command byte and loads the target.
// Assumes cmd_valid is a one-cycle pulse from the APB front end on pclk.
`timescale 1ns/1ps
module counter_cmd_exec
#(
  parameter int NUM_PULSE_CMP = 5
)
(
  input  wire logic                    pclk,          // System clock.
  input  wire logic                    presetn,       // Async reset, low.
  input  wire logic                    cmd_valid,     // Command written.
  input  wire logic [7:0]              cmd_byte,      // Written command.
  input  wire logic [23:0]             data_word,     // Assembled data.
  output logic [23:0]                  pulse_count,   // Pulse counter.
  output logic [23:0]                  dev_count,     // Deviation counter.
  output logic [NUM_PULSE_CMP*24-1:0]  pulse_cmp,     // Compare registers.
  output logic [23:0]                  dev_cmp1,      // Deviation cmp 1.
  output logic [23:0]                  dev_cmp2       // Deviation cmp 2.
);

  logic [3:0] code;

  // Only the low nibble selects the command.
  assign code = cmd_byte[3:0];

  //////////////////////////////////////////////////////////////////////////////

  // Pulse counter preset loads the full signed 24-bit word.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_count <= counter_cmd_pkg::RST_COUNT;
    else if (cmd_valid && code == counter_cmd_pkg::CMD_PULSE_PRESET)
      pulse_count <= data_word;
  end

  // Deviation counter preset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dev_count <= counter_cmd_pkg::RST_COUNT;
    else if (cmd_valid && code == counter_cmd_pkg::CMD_DEV_PRESET)
      dev_count <= data_word;
  end

  // Five pulse compare registers share one loading path.
  for (genvar i = 0; i < NUM_PULSE_CMP; i++)
  begin : g_pcmp
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        pulse_cmp[i*24 +: 24] <= counter_cmd_pkg::RST_PULSE_CMP;
      else if (cmd_valid &&
               code == counter_cmd_pkg::CMD_PULSE_CMP1 + 4'(i))
        pulse_cmp[i*24 +: 24] <= data_word;
    end
  end

  // Deviation compare registers; register two holds a magnitude.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dev_cmp1 <= counter_cmd_pkg::RST_DEV_CMP;
      dev_cmp2 <= counter_cmd_pkg::RST_DEV_CMP;
    end
    else if (cmd_valid && code == counter_cmd_pkg::CMD_DEV_CMP1)
      dev_cmp1 <= data_word;
    else if (cmd_valid && code == counter_cmd_pkg::CMD_DEV_CMP2)
      dev_cmp2 <= data_word;
  end

endmodule // counter_cmd_exec

// File: logic/counter_command_port.sv
// Counter command port: APB slave holding the three counter data bytes
// and the command byte, which drives the command executor.
// Assumes a single 25 MHz pclk and an APB master on the same clock.
//
// Overview of operation
// - Low nibble of command byte selects the command; done within 200 ns.
// - Code 00 presets the pulse counter from the three data bytes.
// - Codes 01 to 05 load pulse compare registers one to five.
// - Code 06 presets the deviation counter from the data bytes.
// - Codes 07 and 08 load deviation compare registers one and two.
// - Pulse counter is zero after reset.
// - Pulse compare values are 24-bit two's complement numbers.
// - Each pulse compare register resets to 800000 hex.
// - Presets are 24-bit two's complement words over three bytes.
// - Deviation counter is zero after reset.
// - Deviation compare register two holds an unsigned magnitude.
// - Counter ports decode apart from drive ports, working independently.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module counter_command_port
#(
  parameter int NUM_PULSE_CMP = 5
)
(
  input  wire logic        pclk,     // APB clock, 25 MHz.
  input  wire logic        presetn,  // APB reset, active low.
  input  wire logic        psel,     // APB select.
  input  wire logic        penable,  // APB enable.
  input  wire logic        pwrite,   // APB direction, high for write.
  input  wire logic [11:0] paddr,    // APB byte address.
  input  wire logic [31:0] pwdata,   // APB write data.
  input  wire logic [3:0]  pstrb,    // APB byte strobes.
  output logic [31:0]      prdata,   // APB read data.
  output logic             pready,   // APB ready.
  output logic             pslverr   // APB error.
);

  logic                       setup;
  logic                       wr_acc;
  logic                       mapped;
  logic [7:0]                 data_high_q;
  logic [7:0]                 data_mid_q;
  logic [7:0]                 data_low_q;
  logic [7:0]                 cmd_q;
  logic                       cmd_valid_q;
  logic [2:0]                 busy_q;
  logic [31:0]                rdata_d;
  logic [23:0]                pulse_count;
  logic [23:0]                dev_count;
  logic [NUM_PULSE_CMP*24-1:0] pulse_cmp;
  logic [23:0]                dev_cmp1;
  logic [23:0]                dev_cmp2;

  // Decode of mapped offsets, shared by write and read answers.
  function automatic logic is_mapped(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (a == counter_cmd_pkg::OFF_COUNTER_COMMAND ||
        a == counter_cmd_pkg::OFF_COUNTER_DATA_HIGH ||
        a == counter_cmd_pkg::OFF_COUNTER_DATA_MID ||
        a == counter_cmd_pkg::OFF_COUNTER_DATA_LOW ||
        a == counter_cmd_pkg::OFF_STATUS ||
        a == counter_cmd_pkg::OFF_PULSE_COUNT ||
        a == counter_cmd_pkg::OFF_DEVIATION_COUNT ||
        a == counter_cmd_pkg::OFF_DEV_CMP1 ||
        a == counter_cmd_pkg::OFF_DEV_CMP2 ||
        a == counter_cmd_pkg::OFF_LAST_COMMAND)
      ok = 1'b1;
    for (int i = 0; i < NUM_PULSE_CMP; i++)
      if (a == counter_cmd_pkg::OFF_PULSE_CMP_BASE + 12'(4 * i))
        ok = 1'b1;
    return ok;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // Setup cycle detection; the answer comes one cycle later.
  assign setup  = psel && !penable;
  assign mapped = is_mapped(paddr);
  assign wr_acc = psel && penable && pready && pwrite && mapped && pstrb[0];

  // Ready and error are registered so the access phase lasts one cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // Counter data bytes; the counter map sits apart from drive ports.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_high_q <= counter_cmd_pkg::RST_DATA_BYTE;
      data_mid_q  <= counter_cmd_pkg::RST_DATA_BYTE;
      data_low_q  <= counter_cmd_pkg::RST_DATA_BYTE;
    end
    else if (wr_acc)
    begin
      if (paddr == counter_cmd_pkg::OFF_COUNTER_DATA_HIGH)
        data_high_q <= pwdata[7:0];
      if (paddr == counter_cmd_pkg::OFF_COUNTER_DATA_MID)
        data_mid_q <= pwdata[7:0];
      if (paddr == counter_cmd_pkg::OFF_COUNTER_DATA_LOW)
        data_low_q <= pwdata[7:0];
    end
  end

  // Command byte write raises a one-cycle execute pulse.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q       <= 8'h00;
      cmd_valid_q <= 1'b0;
    end
    else
    begin
      cmd_valid_q <= wr_acc &&
                     paddr == counter_cmd_pkg::OFF_COUNTER_COMMAND;
      if (wr_acc && paddr == counter_cmd_pkg::OFF_COUNTER_COMMAND)
        cmd_q <= pwdata[7:0];
    end
  end

  // Busy flag covers the command's execution, readable in status.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_q <= 3'h0;
    else if (wr_acc && paddr == counter_cmd_pkg::OFF_COUNTER_COMMAND)
      busy_q <= counter_cmd_pkg::CMD_BUSY_CYC;
    else if (busy_q != 3'h0)
      busy_q <= busy_q - 3'h1;
  end

  //////////////////////////////////////////////////////////////////////////////

  // Executor loads counters and compare registers from the data bytes.
  counter_cmd_exec #(
    .NUM_PULSE_CMP (NUM_PULSE_CMP)
  ) u_exec (
    .pclk        (pclk),
    .presetn     (presetn),
    .cmd_valid   (cmd_valid_q),
    .cmd_byte    (cmd_q),
    .data_word   ({data_high_q, data_mid_q, data_low_q}),
    .pulse_count (pulse_count),
    .dev_count   (dev_count),
    .pulse_cmp   (pulse_cmp),
    .dev_cmp1    (dev_cmp1),
    .dev_cmp2    (dev_cmp2)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Read multiplexer; command and data ports read back their last write.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      counter_cmd_pkg::OFF_COUNTER_COMMAND:   rdata_d = {24'h0, cmd_q};
      counter_cmd_pkg::OFF_COUNTER_DATA_HIGH: rdata_d = {24'h0, data_high_q};
      counter_cmd_pkg::OFF_COUNTER_DATA_MID:  rdata_d = {24'h0, data_mid_q};
      counter_cmd_pkg::OFF_COUNTER_DATA_LOW:  rdata_d = {24'h0, data_low_q};
      counter_cmd_pkg::OFF_STATUS:
        rdata_d = {31'h0, (busy_q != 3'h0) | cmd_valid_q};
      counter_cmd_pkg::OFF_PULSE_COUNT:     rdata_d = {8'h0, pulse_count};
      counter_cmd_pkg::OFF_DEVIATION_COUNT: rdata_d = {8'h0, dev_count};
      counter_cmd_pkg::OFF_DEV_CMP1:        rdata_d = {8'h0, dev_cmp1};
      counter_cmd_pkg::OFF_DEV_CMP2:        rdata_d = {8'h0, dev_cmp2};
      counter_cmd_pkg::OFF_LAST_COMMAND:
        rdata_d = {28'h0, cmd_q[3:0]};
      default:
      begin
        for (int i = 0; i < NUM_PULSE_CMP; i++)
          if (paddr == counter_cmd_pkg::OFF_PULSE_CMP_BASE + 12'(4 * i))
            rdata_d = {8'h0, pulse_cmp[i*24 +: 24]};
      end
    endcase
  end

  // Read data is captured in the setup cycle and held through access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rdata_d;
    else if (setup)
      prdata <= 32'h0000_0000;
  end

endmodule // counter_command_port

// File: sim/counter_command_port_props.sv
// Checker for the counter command port APB slave.
// Assumes it is bound to counter_command_port and sees its ports only.
`timescale 1ns/1ps
module counter_command_port_props
#(
  parameter int NUM_PULSE_CMP = 5
)
(
  input wire logic        pclk,    // Clock.
  input wire logic        presetn, // Reset, low.
  input wire logic        psel,    // Select.
  input wire logic        penable, // Enable.
  input wire logic        pwrite,  // Direction.
  input wire logic [11:0] paddr,   // Address.
  input wire logic [31:0] pwdata,  // Write data.
  input wire logic [3:0]  pstrb,   // Strobes.
  input wire logic [31:0] prdata,  // Read data.
  input wire logic        pready,  // Ready.
  input wire logic        pslverr  // Error.
);
  logic       loaded_q;                      // Command seen since reset.
  logic [3:0] cmd_q;                         // Last command nibble.
  wire  logic done = psel && penable && pready;

  // Tracks command writes so reset values can be told from loaded ones.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loaded_q <= 1'b0;
      cmd_q    <= 4'h0;
    end
    else if (done && pwrite && pstrb[0] &&
             paddr == counter_cmd_pkg::OFF_COUNTER_COMMAND)
    begin
      loaded_q <= 1'b1;
      cmd_q    <= pwdata[3:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence rd_s(a); done && !pwrite && paddr == a; endsequence
  sequence fresh_s(a); done && !pwrite && !loaded_q && paddr == a;
  endsequence

  ////////////////////////////////////////
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("No ready after setup.");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("Ready outside an access.");
  a_err_unmapped: assert property
    (done && paddr[11:6] != 6'h00 |-> pslverr)
    else $error("Unmapped access not refused.");
  a_err_read_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("Refused access returned data.");
  a_pulse_rst_zero: assert property
    (fresh_s(counter_cmd_pkg::OFF_PULSE_COUNT) |-> prdata == 32'h0)
    else $error("Pulse count not zero after reset.");
  a_dev_rst_zero: assert property
    (fresh_s(counter_cmd_pkg::OFF_DEVIATION_COUNT) |-> prdata == 32'h0)
    else $error("Deviation count not zero after reset.");
  a_cmp_rst_value: assert property
    (fresh_s(counter_cmd_pkg::OFF_PULSE_CMP_BASE) |-> prdata == 32'h00800000)
    else $error("Compare register reset value wrong.");
  a_last_cmd_nibble: assert property
    (rd_s(counter_cmd_pkg::OFF_LAST_COMMAND) |-> prdata == {28'h0, cmd_q})
    else $error("Last command nibble wrong.");
endmodule // counter_command_port_props

bind counter_command_port counter_command_port_props
  #(.NUM_PULSE_CMP(NUM_PULSE_CMP)) u_props
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));

// File: sim/apb_host_model.sv
// Host processor model: an APB master with transfer and load tasks.
// Assumes the slave answers with pready on the shared pclk.
`timescale 1ns/1ps
module apb_host_model
(
  input  wire logic        pclk,    // Clock.
  input  wire logic [31:0] prdata,  // Read data.
  input  wire logic        pready,  // Ready.
  input  wire logic        pslverr, // Error.
  output logic             psel,    // Select.
  output logic             penable, // Enable.
  output logic             pwrite,  // Direction.
  output logic [11:0]      paddr,   // Address.
  output logic [31:0]      pwdata,  // Write data.
  output logic [3:0]       pstrb    // Strobes.
);
  // Strobes for the next transfer; a test clears them to try a refusal.
  logic [3:0] strb_q = 4'hF;

  // Idle bus at time zero.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end

  ////////////////////////////////////////
  // One transfer; released data is inverted so nothing stale looks valid.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb_q;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask

  // Data bytes high to low, command last, then the execution time.
  task automatic load(input logic [7:0] c, input logic [23:0] v);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, counter_cmd_pkg::OFF_COUNTER_DATA_HIGH,
         {24'h0, v[23:16]}, r, e);
    xfer(1'b1, counter_cmd_pkg::OFF_COUNTER_DATA_MID,
         {24'h0, v[15:8]}, r, e);
    xfer(1'b1, counter_cmd_pkg::OFF_COUNTER_DATA_LOW,
         {24'h0, v[7:0]}, r, e);
    xfer(1'b1, counter_cmd_pkg::OFF_COUNTER_COMMAND,
         {24'h0, c}, r, e);
    repeat (counter_cmd_pkg::CMD_MAX_CYC) @(posedge pclk);
  endtask
endmodule // apb_host_model

// File: sim/counter_command_port_tb.sv
// Testbench for the counter command port.
// Assumes the host model drives APB and the checker is bound in.
`timescale 1ns/1ps
module counter_command_port_tb;
  logic        pclk = 1'b0;    // Clock.
  logic        presetn = 1'b0; // Reset, low.
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          err_count, checks;
  logic [23:0] vals [9] = '{24'h7FFFFF, 24'h800001, 24'hFFFFF6,
    24'h00000A, 24'hFFFFFF, 24'h000000, 24'h800001, 24'hFFFFF6, 24'hFFFFFF};

  // Clock of 40 ns.
  always #20 pclk = ~pclk;

  apb_host_model host (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  counter_command_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
    host.xfer(1'b0, a, 32'h0, rd, er);
    check(rd, want);
  endtask

  // Register loaded by each command code.
  function automatic logic [11:0] target(input int c);
    if (c == 0) return counter_cmd_pkg::OFF_PULSE_COUNT;
    if (c < 6) return counter_cmd_pkg::OFF_PULSE_CMP_BASE + 12'(4 * (c - 1));
    if (c == 6) return counter_cmd_pkg::OFF_DEVIATION_COUNT;
    return (c == 7) ? counter_cmd_pkg::OFF_DEV_CMP1 : counter_cmd_pkg::OFF_DEV_CMP2;
  endfunction

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d.", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial
  begin
    repeat (4000) @(posedge pclk);
    err_count++;
    print_verdict;
  end

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(counter_cmd_pkg::OFF_PULSE_COUNT, 32'h0);
    rd_chk(counter_cmd_pkg::OFF_DEVIATION_COUNT, 32'h0);
    for (int i = 1; i < 6; i++) rd_chk(target(i), 32'h00800000);
    $display("Test reset values done.");
    for (int c = 0; c < 9; c++)
    begin
      host.load(8'hA0 | 8'(c), vals[c]);
      rd_chk(target(c), {8'h00, vals[c]});
    end
    $display("Test command codes done.");
    host.load(8'h59, 24'h123456);
    for (int c = 0; c < 9; c++) rd_chk(target(c), {8'h00, vals[c]});
    rd_chk(counter_cmd_pkg::OFF_LAST_COMMAND, 32'h00000009);
    rd_chk(counter_cmd_pkg::OFF_COUNTER_DATA_HIGH, 32'h00000012);
    rd_chk(counter_cmd_pkg::OFF_COUNTER_DATA_MID, 32'h00000034);
    rd_chk(counter_cmd_pkg::OFF_COUNTER_DATA_LOW, 32'h00000056);
    rd_chk(counter_cmd_pkg::OFF_STATUS, 32'h00000000);
    $display("Test idle code done.");
    host.strb_q = 4'h0;
    host.xfer(1'b1, counter_cmd_pkg::OFF_COUNTER_DATA_HIGH,
              32'h000000EE, rd, er);
    host.strb_q = 4'hF;
    check({31'h0, er}, 32'h00000000);
    rd_chk(counter_cmd_pkg::OFF_COUNTER_DATA_HIGH, 32'h00000012);
    $display("Test strobe refusal done.");
    host.xfer(1'b0, 12'h040, 32'h0, rd, er);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h00000001);
    $display("Test unmapped address done.");
    print_verdict;
  end
endmodule // counter_command_port_tb
